/* File: logic/pmdl_pkg.sv */
package pmdl_pkg;
  // ==========================================
  // Register offsets
  localparam logic [5:0] ADDR_TX_FIFO   = 6'h37;
  localparam logic [5:0] ADDR_CONTROL   = 6'h3d;
  localparam logic [5:0] ADDR_HOLD      = 6'h3e;
  localparam logic [5:0] ADDR_EDGE_SEL  = 6'h3f;
  // ==========================================
  // Field positions of the control register
  localparam int BIT_DEJIT   = 7;
  localparam int BIT_IPOL    = 6;
  localparam int BIT_RHIE    = 5;
  localparam int BIT_RXEN    = 4;
  localparam int BIT_EOM     = 2;
  localparam int BIT_THIE    = 1;
  localparam int BIT_TXEN    = 0;
  // Field positions of the edge select register
  localparam int BIT_RISE    = 1;
  localparam int BIT_FALL    = 0;
  // ==========================================
  // Reset values
  localparam logic [7:0] CONTROL_RST  = 8'h00;
  localparam logic [7:0] HOLD_RST     = 8'h00;
  localparam logic [1:0] EDGE_RST     = 2'h0;
  // ==========================================
  // Serial constants
  localparam logic [7:0]  HDLC_FLAG    = 8'h7e;
  localparam logic [15:0] CRC_INIT     = 16'hffff;
  localparam logic [15:0] CRC_POLY     = 16'h8408;
  localparam logic [2:0]  ONES_LIMIT   = 3'h5;
  localparam logic [3:0]  BYTE_LAST    = 4'h7;
  localparam logic [3:0]  FCS_LAST     = 4'hf;

  typedef enum logic [1:0] {
    PMDL_FLAG,
    PMDL_DATA,
    PMDL_FCS,
    PMDL_ABORT
  } pmdl_state_e;
endpackage : pmdl_pkg

/* File: logic/pmdl_edge_det.sv */
`timescale 1ns/100ps
module pmdl_edge_det #(
  parameter int                 N_ALARM   = 8,
  parameter logic [N_ALARM-1:0] RISE_ONLY = '0
) (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               nrst,
  // Edge selection
  input  wire logic               rise_sel,
  input  wire logic               fall_sel,
  // Alarms and request set pulses
  input  wire logic [N_ALARM-1:0] alarm,
  output logic      [N_ALARM-1:0] irq_set
);
  logic [N_ALARM-1:0] alarm_reg;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      alarm_reg <= '0;
    end else begin
      alarm_reg <= alarm;
    end
  end

  genvar g;
  generate
    for (g = 0; g < N_ALARM; g++) begin : g_alarm
      wire rise_ev = alarm[g] & ~alarm_reg[g];
      wire fall_ev = ~alarm[g] & alarm_reg[g];
      // Some request bits ignore the selection and always follow entry
      assign irq_set[g] = RISE_ONLY[g] ? rise_ev :
                          ((rise_sel & rise_ev) | (fall_sel & fall_ev));
    end
  endgenerate

  // ==========================================
  // Checks
  a_no_sel_blocks: assert property (@(posedge core_clk) disable iff (!nrst)
    (!rise_sel && !fall_sel) |-> ((irq_set & ~RISE_ONLY) == '0))
    else $error("request set with no edge selected");
  a_rise_sets: assert property (@(posedge core_clk) disable iff (!nrst)
    rise_sel |-> ((alarm & ~$past(alarm) & ~irq_set) == '0))
    else $error("rising alarm did not set request");
  a_fixed_rising: assert property (@(posedge core_clk) disable iff (!nrst)
    ((irq_set & RISE_ONLY) == (alarm & ~$past(alarm) & RISE_ONLY)))
    else $error("fixed request bits did not follow rising edge");
  a_fall_sets: assert property (@(posedge core_clk) disable iff (!nrst)
    fall_sel |-> ((~alarm & $past(alarm) & ~RISE_ONLY & ~irq_set) == '0))
    else $error("falling alarm did not set request");
  c_both_edges: cover property (@(posedge core_clk) disable iff (!nrst)
    rise_sel && fall_sel && (irq_set != '0));
endmodule : pmdl_edge_det

/* File: logic/pmdl_tx_ctl.sv */
`timescale 1ns/100ps
module pmdl_tx_ctl #(
  parameter int                 FIFO_DEPTH = 16,
  parameter int                 N_ALARM    = 8,
  parameter logic [N_ALARM-1:0] RISE_ONLY  = '0
) (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               nrst,
  // Processor register port
  input  wire logic [5:0]         cpu_addr,
  input  wire logic [7:0]         cpu_wdata,
  input  wire logic               cpu_wr,
  input  wire logic               cpu_rd,
  output logic      [7:0]         cpu_rdata,
  // Counter low-byte read from the counter bank
  input  wire logic               ctr_lo_read,
  input  wire logic [7:0]         ctr_high_byte,
  // Transmit framer side
  input  wire logic               frame_format_select,
  input  wire logic               pmdl_bit_en,
  input  wire logic               ext_cbit,
  input  wire logic               stuff_cbit,
  output logic                    pmdl_cbit,
  // Control outputs to the rest of the device
  output logic                    dejitter_on,
  output logic                    irq_active_low,
  output logic                    rx_half_irq_en,
  output logic                    rx_hdlc_en,
  output logic                    tx_half_irq_en,
  output logic                    pmdl_tx_enable,
  output logic                    tx_msg_done,
  output logic                    tx_abort,
  // Alarm edge logic
  input  wire logic [N_ALARM-1:0] alarm,
  output logic      [N_ALARM-1:0] irq_set
);
  localparam int PW = $clog2(FIFO_DEPTH);

  // ==========================================
  // Register decode
  wire wr_ctl   = cpu_wr && (cpu_addr == pmdl_pkg::ADDR_CONTROL);
  wire wr_edge  = cpu_wr && (cpu_addr == pmdl_pkg::ADDR_EDGE_SEL);
  wire wr_fifo  = cpu_wr && (cpu_addr == pmdl_pkg::ADDR_TX_FIFO);

  logic [7:0]           ctl_reg;
  logic [7:0]           hold_reg;
  logic [1:0]           edge_reg;
  logic                 eom_reg;
  logic [7:0]           fifo_mem [FIFO_DEPTH];
  logic [PW-1:0]        wr_ptr_reg;
  logic [PW-1:0]        rd_ptr_reg;
  logic [PW:0]          count_reg;
  pmdl_pkg::pmdl_state_e state_reg;
  logic [15:0]          shift_reg;
  logic [15:0]          crc_reg;
  logic [3:0]           bit_cnt_reg;
  logic [2:0]           ones_reg;
  logic                 cbit_reg;
  logic                 eom_clr;

  assign pmdl_tx_enable = ctl_reg[pmdl_pkg::BIT_TXEN];
  assign dejitter_on    = ctl_reg[pmdl_pkg::BIT_DEJIT];
  assign irq_active_low = ctl_reg[pmdl_pkg::BIT_IPOL];
  assign rx_half_irq_en = ctl_reg[pmdl_pkg::BIT_RHIE];
  assign rx_hdlc_en     = ctl_reg[pmdl_pkg::BIT_RXEN];
  assign tx_half_irq_en = ctl_reg[pmdl_pkg::BIT_THIE];

  wire [7:0] ctl_view = {ctl_reg[7:3], eom_reg, ctl_reg[1:0]};
  wire [7:0] rd_mux   = (cpu_addr == pmdl_pkg::ADDR_CONTROL)  ? ctl_view :
                        (cpu_addr == pmdl_pkg::ADDR_HOLD)     ? hold_reg :
                        (cpu_addr == pmdl_pkg::ADDR_EDGE_SEL) ? {6'h00, edge_reg} :
                        8'h00;

  // ==========================================
  // Control, edge select and hold registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctl_reg  <= pmdl_pkg::CONTROL_RST;
      edge_reg <= pmdl_pkg::EDGE_RST;
      hold_reg <= pmdl_pkg::HOLD_RST;
    end else begin
      if (wr_ctl) begin
        ctl_reg <= {cpu_wdata[7:4], 1'b0, 1'b0, cpu_wdata[1:0]};
      end
      // Upper bits are not stored; software is expected to write zeros there
      if (wr_edge) begin
        edge_reg <= cpu_wdata[1:0];
      end
      if (ctr_lo_read) begin
        hold_reg <= ctr_high_byte;
      end
    end
  end

  // Software sets, hardware clears after the FCS; a set in the same cycle wins
  wire eom_set = wr_ctl && cpu_wdata[pmdl_pkg::BIT_EOM] && cpu_wdata[pmdl_pkg::BIT_TXEN];
  wire tx_off  = !pmdl_tx_enable;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      eom_reg   <= 1'b0;
      cpu_rdata <= 8'h00;
    end else begin
      eom_reg   <= eom_set | (eom_reg & ~eom_clr & ~tx_off);
      if (cpu_rd) begin
        cpu_rdata <= rd_mux;
      end
    end
  end

  // ==========================================
  // Transmit FIFO
  wire fifo_empty = (count_reg == '0);
  wire fifo_full  = (count_reg == (PW+1)'(FIFO_DEPTH));
  wire push       = wr_fifo && pmdl_tx_enable && !fifo_full;
  wire in_body    = (state_reg == pmdl_pkg::PMDL_DATA) || (state_reg == pmdl_pkg::PMDL_FCS);
  wire stuff_now  = in_body && (ones_reg == pmdl_pkg::ONES_LIMIT);
  wire byte_end   = pmdl_bit_en && (state_reg != pmdl_pkg::PMDL_FCS)
                    && (bit_cnt_reg == pmdl_pkg::BYTE_LAST) && !stuff_now;
  wire pop        = byte_end && !fifo_empty && (state_reg != pmdl_pkg::PMDL_ABORT);
  wire [7:0] head = fifo_mem[rd_ptr_reg];

  always_ff @(posedge core_clk) begin
    if (push) begin
      fifo_mem[wr_ptr_reg] <= cpu_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (tx_off) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) wr_ptr_reg <= (wr_ptr_reg == PW'(FIFO_DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      if (pop)  rd_ptr_reg <= (rd_ptr_reg == PW'(FIFO_DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // ==========================================
  // HDLC serialiser, LSB first, one bit per framer enable
  wire out_bit   = stuff_now ? 1'b0 : shift_reg[0];
  wire fcs_end   = pmdl_bit_en && (state_reg == pmdl_pkg::PMDL_FCS)
                   && (bit_cnt_reg == pmdl_pkg::FCS_LAST) && !stuff_now;
  wire crc_fb    = crc_reg[0] ^ shift_reg[0];
  wire [15:0] crc_step = {1'b0, crc_reg[15:1]} ^ (crc_fb ? pmdl_pkg::CRC_POLY : 16'h0000);
  // Leaving data with an empty FIFO: FCS if the message is closed, else abort
  wire [15:0] crc_last = crc_step;
  assign eom_clr       = fcs_end;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg   <= pmdl_pkg::PMDL_FLAG;
      shift_reg   <= {8'h00, pmdl_pkg::HDLC_FLAG};
      crc_reg     <= pmdl_pkg::CRC_INIT;
      bit_cnt_reg <= 4'h0;
      ones_reg    <= 3'h0;
      tx_msg_done <= 1'b0;
      tx_abort    <= 1'b0;
    end else if (tx_off) begin
      state_reg   <= pmdl_pkg::PMDL_FLAG;
      shift_reg   <= {8'h00, pmdl_pkg::HDLC_FLAG};
      bit_cnt_reg <= 4'h0;
      ones_reg    <= 3'h0;
      tx_msg_done <= 1'b0;
      tx_abort    <= 1'b0;
    end else begin
      tx_msg_done <= fcs_end;
      tx_abort    <= 1'b0;
      if (pmdl_bit_en) begin
        ones_reg <= (stuff_now || !out_bit || !in_body) ? 3'h0 : ones_reg + 3'h1;
        if (!stuff_now) begin
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          shift_reg   <= {1'b0, shift_reg[15:1]};
          if (state_reg == pmdl_pkg::PMDL_DATA) crc_reg <= crc_step;
        end
        case (state_reg)
          pmdl_pkg::PMDL_FLAG, pmdl_pkg::PMDL_ABORT: begin
            if (byte_end) begin
              bit_cnt_reg <= 4'h0;
              crc_reg     <= pmdl_pkg::CRC_INIT;
              if (pop) begin                       // An abort always closes with a flag, since pop is blocked in the abort state; data can follow only from a flag
                state_reg <= pmdl_pkg::PMDL_DATA;
                shift_reg <= {8'h00, head};
              end else begin
                state_reg <= pmdl_pkg::PMDL_FLAG;
                shift_reg <= {8'h00, pmdl_pkg::HDLC_FLAG};
              end
            end
          end
          pmdl_pkg::PMDL_DATA: begin
            if (byte_end) begin
              bit_cnt_reg <= 4'h0;
              if (!fifo_empty) begin
                shift_reg <= {8'h00, head};
              end else if (eom_reg) begin
                state_reg <= pmdl_pkg::PMDL_FCS;
                shift_reg <= ~crc_last;
              end else begin
                state_reg <= pmdl_pkg::PMDL_ABORT;
                shift_reg <= 16'h00ff;
                tx_abort  <= 1'b1;
              end
            end
          end
          pmdl_pkg::PMDL_FCS: begin
            if (fcs_end) begin
              state_reg   <= pmdl_pkg::PMDL_FLAG;
              shift_reg   <= {8'h00, pmdl_pkg::HDLC_FLAG};
              bit_cnt_reg <= 4'h0;
            end
          end
          default: state_reg <= pmdl_pkg::PMDL_FLAG;
        endcase
      end
    end
  end

  // ==========================================
  // Source select for the PMDL C-bits
  wire src_bit = pmdl_tx_enable      ? out_bit :
                 frame_format_select ? stuff_cbit : ext_cbit;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cbit_reg <= 1'b0;
    end else if (pmdl_bit_en) begin
      cbit_reg <= src_bit;
    end
  end
  assign pmdl_cbit = cbit_reg;

  // ==========================================
  // Alarm edge selection
  pmdl_edge_det #(
    .N_ALARM   (N_ALARM),
    .RISE_ONLY (RISE_ONLY)
  ) u_edge (
    .core_clk (core_clk),
    .nrst     (nrst),
    .rise_sel (edge_reg[pmdl_pkg::BIT_RISE]),
    .fall_sel (edge_reg[pmdl_pkg::BIT_FALL]),
    .alarm    (alarm),
    .irq_set  (irq_set)
  );

  // ==========================================
  // Checks
  a_src_enabled: assert property (@(posedge core_clk) disable iff (!nrst)
    (pmdl_bit_en && pmdl_tx_enable) |=> (pmdl_cbit == $past(out_bit)))
    else $error("enabled PMDL bit not from transmitter");
  a_src_disabled: assert property (@(posedge core_clk) disable iff (!nrst)
    (pmdl_bit_en && !pmdl_tx_enable)
    |=> (pmdl_cbit == ($past(frame_format_select) ? $past(stuff_cbit) : $past(ext_cbit))))
    else $error("disabled PMDL bit from wrong source");
  a_idle_flags: assert property (@(posedge core_clk) disable iff (!nrst)
    (byte_end && state_reg == pmdl_pkg::PMDL_FLAG && fifo_empty && pmdl_tx_enable)
    |=> (state_reg == pmdl_pkg::PMDL_FLAG && shift_reg[7:0] == pmdl_pkg::HDLC_FLAG))
    else $error("idle transmitter not sending flags");
  a_disable_flush: assert property (@(posedge core_clk) disable iff (!nrst)
    (wr_ctl && !cpu_wdata[pmdl_pkg::BIT_TXEN]) |=> ##1 (count_reg == '0 && !tx_msg_done))
    else $error("disable did not flush FIFO");
  a_fcs_after_eom: assert property (@(posedge core_clk) disable iff (!nrst)
    (byte_end && state_reg == pmdl_pkg::PMDL_DATA && fifo_empty && eom_reg && pmdl_tx_enable)
    |=> (state_reg == pmdl_pkg::PMDL_FCS && shift_reg == ~$past(crc_step)))
    else $error("FCS not started after last byte");
  a_hold_capture: assert property (@(posedge core_clk) disable iff (!nrst)
    ctr_lo_read |=> (hold_reg == $past(ctr_high_byte)))
    else $error("hold register missed high byte");
  a_hold_keeps: assert property (@(posedge core_clk) disable iff (!nrst)
    !ctr_lo_read |=> $stable(hold_reg))
    else $error("hold register changed without low-byte read");
  a_edge_reserved: assert property (@(posedge core_clk) disable iff (!nrst)
    (cpu_rd && cpu_addr == pmdl_pkg::ADDR_EDGE_SEL) |=> (cpu_rdata[7:2] == 6'h00))
    else $error("reserved edge bits read nonzero");
  c_msg_sent: cover property (@(posedge core_clk) disable iff (!nrst) tx_msg_done);
  c_abort:    cover property (@(posedge core_clk) disable iff (!nrst) tx_abort);
  c_fifo_full: cover property (@(posedge core_clk) disable iff (!nrst) fifo_full);
endmodule : pmdl_tx_ctl

/* File: tb/pmdl_framer_model.sv */
`timescale 1ns/100ps
// ==========================================
// Framer side: takes one PMDL bit every four cycles and unstuffs frames
module pmdl_framer_model (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  // Bit exchange with the block
  input  wire logic pmdl_cbit,
  output logic      pmdl_bit_en,
  output logic      ext_cbit,
  output logic      stuff_cbit,
  // Expected sources for the bench
  output logic      bit_strb,
  output logic      exp_ext,
  output logic      exp_stuff
);
  logic [1:0] cnt_reg;
  logic [1:0] pat_reg;
  logic [7:0] shift_reg = 8'h00;
  logic [7:0] b;
  logic       bits[$];
  logic [7:0] rx_q[$];
  int         ones = 0;
  int         frame_count = 0;

  // ext_cbit moves at every taken bit, stuff_cbit at every second, so a wrong selection shows quickly
  assign ext_cbit   = pat_reg[0];
  assign stuff_cbit = pat_reg[1];

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg     <= 2'h0;
      pat_reg     <= 2'h1;
      pmdl_bit_en <= 1'h0;
      bit_strb    <= 1'h0;
      exp_ext     <= 1'h0;
      exp_stuff   <= 1'h0;
    end else begin
      cnt_reg     <= cnt_reg + 2'h1;
      pmdl_bit_en <= (cnt_reg == 2'h3);
      bit_strb    <= pmdl_bit_en;
      if (pmdl_bit_en) begin
        exp_ext   <= ext_cbit;
        exp_stuff <= stuff_cbit;
        pat_reg   <= pat_reg + 2'h1;
      end
    end
  end

  // Seven ones in a row is an abort, so the partial frame is dropped
  always @(posedge core_clk) begin
    if (nrst && bit_strb) begin
      shift_reg = {pmdl_cbit, shift_reg[7:1]};
      if (shift_reg == pmdl_pkg::HDLC_FLAG) begin
        if (bits.size() > 7 && (bits.size() - 7) % 8 == 0) begin
          for (int i = 0; i < bits.size() - 7; i++) begin
            b = {bits[i], b[7:1]};
            if (i % 8 == 7) rx_q.push_back(b);
          end
          frame_count++;
        end
        bits.delete();
        ones = 0;
      end else if (ones == 5 && !pmdl_cbit) begin
        ones = 0;
      end else begin
        bits.push_back(pmdl_cbit);
        ones = pmdl_cbit ? ones + 1 : 0;
        if (ones == 7) bits.delete();
      end
    end
  end
endmodule : pmdl_framer_model

/* File: tb/tb_pmdl_tx_enable_irq_edge_ctl.sv */
`timescale 1ns/100ps
module tb_pmdl_tx_enable_irq_edge_ctl;
  logic       core_clk, nrst, cpu_wr, cpu_rd, ctr_lo_read, frame_format_select;
  logic [5:0] cpu_addr;
  logic [7:0] cpu_wdata, cpu_rdata, ctr_high_byte, alarm, irq_set;
  logic       pmdl_bit_en, ext_cbit, stuff_cbit, pmdl_cbit, bit_strb, exp_ext, exp_stuff;
  logic       dejitter_on, irq_active_low, rx_half_irq_en, rx_hdlc_en, tx_half_irq_en;
  logic       pmdl_tx_enable, tx_msg_done, tx_abort;
  int         fail_count = 0, check_count = 0, cycles = 0, done_count = 0, abort_count = 0;

  pmdl_tx_ctl #(.N_ALARM(8), .RISE_ONLY(8'hf0)) dut_u (.core_clk(core_clk), .nrst(nrst),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_rdata(cpu_rdata), .ctr_lo_read(ctr_lo_read), .ctr_high_byte(ctr_high_byte),
    .frame_format_select(frame_format_select), .pmdl_bit_en(pmdl_bit_en),
    .ext_cbit(ext_cbit), .stuff_cbit(stuff_cbit), .pmdl_cbit(pmdl_cbit),
    .dejitter_on(dejitter_on), .irq_active_low(irq_active_low),
    .rx_half_irq_en(rx_half_irq_en), .rx_hdlc_en(rx_hdlc_en),
    .tx_half_irq_en(tx_half_irq_en), .pmdl_tx_enable(pmdl_tx_enable),
    .tx_msg_done(tx_msg_done), .tx_abort(tx_abort), .alarm(alarm), .irq_set(irq_set));
  pmdl_framer_model framer_u (.core_clk(core_clk), .nrst(nrst), .pmdl_cbit(pmdl_cbit),
    .pmdl_bit_en(pmdl_bit_en), .ext_cbit(ext_cbit), .stuff_cbit(stuff_cbit),
    .bit_strb(bit_strb), .exp_ext(exp_ext), .exp_stuff(exp_stuff));

  // ==========================================
  // Shared tasks
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
    end
  endtask : chk8
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk);
    cpu_addr  <= a;
    cpu_wdata <= d;
    cpu_wr    <= 1'h1;
    @(posedge core_clk);
    cpu_wr <= 1'h0;
  endtask : wr
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    cpu_addr <= a;
    cpu_rd   <= 1'h1;
    @(posedge core_clk);
    cpu_rd <= 1'h0;
    @(negedge core_clk);
    chk8(cpu_rdata, exp);
  endtask : rd_chk
  task automatic wait_bit;
    do @(negedge core_clk); while (bit_strb !== 1'h1);
  endtask : wait_bit
  task automatic flag_chk;
    logic [7:0] sh;
    int         hits;
    sh   = 8'h00;
    hits = 0;
    repeat (48) begin
      wait_bit();
      sh = {pmdl_cbit, sh[7:1]};
      if (sh === pmdl_pkg::HDLC_FLAG) hits++;
    end
    chk8({7'h00, hits >= 4}, 8'h01);
  endtask : flag_chk
  task automatic src_chk(input logic sel);
    @(posedge core_clk);
    frame_format_select <= sel;
    wait_bit();
    repeat (8) begin
      wait_bit();
      chk8({7'h00, pmdl_cbit}, {7'h00, sel ? exp_stuff : exp_ext});
    end
  endtask : src_chk
  task automatic lo_read(input logic [7:0] h);
    @(posedge core_clk);
    ctr_lo_read   <= 1'h1;
    ctr_high_byte <= h;
    @(posedge core_clk);
    ctr_lo_read   <= 1'h0;
    ctr_high_byte <= ~h;
  endtask : lo_read
  function automatic logic [15:0] fcs_of(input logic [7:0] d[$]);
    logic [15:0] c;
    c = pmdl_pkg::CRC_INIT;
    foreach (d[i])
      for (int k = 0; k < 8; k++)
        c = (c >> 1) ^ ((c[0] ^ d[i][k]) ? pmdl_pkg::CRC_POLY : 16'h0000);
    return ~c;
  endfunction : fcs_of

  // ==========================================
  // Scenarios
  task automatic t_regs;
    rd_chk(pmdl_pkg::ADDR_CONTROL, pmdl_pkg::CONTROL_RST);
    rd_chk(pmdl_pkg::ADDR_HOLD, pmdl_pkg::HOLD_RST);
    rd_chk(pmdl_pkg::ADDR_EDGE_SEL, 8'h00);
    rd_chk(6'h20, 8'h00);
    wr(pmdl_pkg::ADDR_CONTROL, 8'hfa);
    rd_chk(pmdl_pkg::ADDR_CONTROL, 8'hf2);
    chk8({dejitter_on, irq_active_low, rx_half_irq_en, rx_hdlc_en, tx_half_irq_en,
          pmdl_tx_enable, 2'h0}, 8'hf8);
    wr(pmdl_pkg::ADDR_CONTROL, 8'h04);
    rd_chk(pmdl_pkg::ADDR_CONTROL, 8'h00);
    src_chk(1'h0);
    src_chk(1'h1);
    $display("test regs and sources done");
  endtask : t_regs
  task automatic t_message;
    logic [7:0]  msg[$] = '{8'h7e, 8'hff, 8'h00, 8'h81};
    logic [15:0] f;
    int          fc, n;
    wr(pmdl_pkg::ADDR_CONTROL, 8'h01);
    @(negedge core_clk);
    chk8({7'h00, pmdl_tx_enable}, 8'h01);
    flag_chk();
    framer_u.rx_q.delete();
    fc = framer_u.frame_count;
    foreach (msg[i]) wr(pmdl_pkg::ADDR_TX_FIFO, msg[i]);
    wr(pmdl_pkg::ADDR_CONTROL, 8'h05);
    n = 0;
    while (framer_u.frame_count == fc && n < 1500) begin
      @(negedge core_clk);
      n++;
    end
    f = fcs_of(msg);
    msg.push_back(f[7:0]);
    msg.push_back(f[15:8]);
    chk8(8'(framer_u.rx_q.size()), 8'h06);
    foreach (msg[i]) chk8(framer_u.rx_q[i], msg[i]);
    chk8(8'(done_count), 8'h01);
    chk8(8'(abort_count), 8'h00);
    rd_chk(pmdl_pkg::ADDR_CONTROL, 8'h01);
    $display("test message done");
  endtask : t_message
  task automatic t_flush;
    repeat (3) wr(pmdl_pkg::ADDR_TX_FIFO, 8'h3c);
    wr(pmdl_pkg::ADDR_CONTROL, 8'h00);
    src_chk(1'h0);
    wr(pmdl_pkg::ADDR_CONTROL, 8'h01);
    flag_chk();
    chk8(8'(done_count + abort_count), 8'h01);
    $display("test flush done");
  endtask : t_flush
  task automatic t_abort;
    int fc, n;
    fc = framer_u.frame_count;
    wr(pmdl_pkg::ADDR_TX_FIFO, 8'h55);
    n = 0;
    while (abort_count == 0 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    chk8(8'(abort_count), 8'h01);
    flag_chk();
    chk8(8'(framer_u.frame_count - fc), 8'h00);
    rd_chk(pmdl_pkg::ADDR_CONTROL, 8'h01);
    $display("test abort done");
  endtask : t_abort
  task automatic t_hold;
    lo_read(8'ha5);
    rd_chk(pmdl_pkg::ADDR_HOLD, 8'ha5);
    rd_chk(pmdl_pkg::ADDR_HOLD, 8'ha5);
    lo_read(8'h5a);
    rd_chk(pmdl_pkg::ADDR_HOLD, 8'h5a);
    $display("test hold done");
  endtask : t_hold
  task automatic t_edges;
    for (int c = 0; c < 4; c++) begin
      wr(pmdl_pkg::ADDR_EDGE_SEL, 8'(c));
      rd_chk(pmdl_pkg::ADDR_EDGE_SEL, 8'(c));
      @(posedge core_clk);
      alarm <= 8'hff;
      @(negedge core_clk);
      chk8(irq_set, (c[1] ? 8'hff : 8'h00) | 8'hf0);
      @(negedge core_clk);
      chk8(irq_set, 8'h00);
      @(posedge core_clk);
      alarm <= 8'h00;
      @(negedge core_clk);
      chk8(irq_set, c[0] ? 8'h0f : 8'h00);
    end
    $display("test edges done");
  endtask : t_edges

  task automatic give_verdict;
    $display("checks %0d failures %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  // ==========================================
  // Clock, watchdog and main sequence
  initial begin
    core_clk = 1'h0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (tx_msg_done === 1'h1) done_count++;
    if (tx_abort === 1'h1) abort_count++;
    if (cycles == 12000) begin
      fail_count++;
      $display("CHECK FAILED t=%0t run too long", $time);
      give_verdict();
    end
  end
  initial begin
    nrst                = 1'h0;
    cpu_addr            = 6'h00;
    cpu_wdata           = 8'h00;
    cpu_wr              = 1'h0;
    cpu_rd              = 1'h0;
    ctr_lo_read         = 1'h0;
    ctr_high_byte       = 8'h00;
    frame_format_select = 1'h0;
    alarm               = 8'h00;
    repeat (16) @(posedge core_clk);
    nrst <= 1'h1;
    t_regs();
    t_message();
    t_flush();
    t_abort();
    t_hold();
    t_edges();
    give_verdict();
  end
endmodule : tb_pmdl_tx_enable_irq_edge_ctl
